//--- src/fdp_pin_ctrl.v
// floppy drive pin control: drive-side outputs, disk change input,
// DMA request/acknowledge routing and an APB register slave.
// assumes drive and DMA pins are asynchronous, core signals on pclk.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
`include "fdp_consts.vh"
module fdp_pin_ctrl
#(
   parameter NCH = 3
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire fdc_seek_in,
   input wire fdc_rw_busy,
   input wire fdc_dma_req,
   input wire ser_dma_req,
   input wire par_dma_req,
   input wire mode_strap,
   input wire disk_change_in,
   input wire iowr_n,
   input wire iord_n,
   input wire [NCH-1:0] dack_n,
   output reg density_select,
   output reg step_dir,
   output reg [1:0] drive_select_n,
   output reg motor_on_0,
   output reg motor_on_1,
   output reg rate_select_out,
   output reg read_gate_diag,
   output reg [NCH-1:0] drq,
   output reg fdc_dack,
   output reg ser_dack,
   output reg par_dack,
   output reg fdc_dma_wr,
   output reg fdc_dma_rd,
   output reg full_infrared_mode
);

////////////////////////////////////////////////////////////////////////
// pin synchronisers

wire strap_s;
wire chg_s;
wire iowr_s;
wire iord_s;
wire [NCH-1:0] dack_s;

// R17: single clock domain
fdp_sync #(.WIDTH(2), .RST_VAL(2'b00)) u_sync_lvl
(
   .pclk(pclk),
   .presetn(presetn),
   .d({mode_strap, disk_change_in}),
   .q({strap_s, chg_s})
);

// active-low pins idle high through reset
fdp_sync #(.WIDTH(NCH + 2), .RST_VAL({(NCH + 2){1'b1}})) u_sync_act
(
   .pclk(pclk),
   .presetn(presetn),
   .d({iowr_n, iord_n, dack_n}),
   .q({iowr_s, iord_s, dack_s})
);

////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] drv_out_q;
reg [7:0] cfg_q;
reg [1:0] dsr_q;
reg [1:0] ccr_q;
reg [1:0] rate_q;
reg [7:0] mode_q;
reg [2*NCH-1:0] map_q;
reg [1:0] strap_cnt_q;
reg strap_done_q;

wire [`FDP_ADDR_W-1:0] addr = paddr[`FDP_ADDR_W-1:0];
wire wr_en = psel & penable & pready & pwrite;

// owner code of one DMA channel, used by request and ack routing
function [1:0] owner;
   input [2*NCH-1:0] map;
   input integer ch;
   begin
      owner = map[2*ch +: 2];
   end
endfunction

// decoded address is valid, used by the error path only; the read mux decodes by case
function hit;
   input [`FDP_ADDR_W-1:0] a;
   begin
      hit = (a == `FDP_OFS_DRV_OUT) || (a == `FDP_OFS_CFG) ||
         (a == `FDP_OFS_DSR) || (a == `FDP_OFS_CCR) ||
         (a == `FDP_OFS_DIN) || (a == `FDP_OFS_MODE) ||
         (a == `FDP_OFS_DMAMAP);
   end
endfunction

// register writes land only at the completing edge
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      drv_out_q <= `FDP_DRVO_RST;
      cfg_q <= `FDP_CFG_RST;
      dsr_q <= `FDP_RATE_RST;
      ccr_q <= `FDP_RATE_RST;
      rate_q <= `FDP_RATE_RST;
      mode_q <= `FDP_MODE_RST;
      map_q <= `FDP_DMAMAP_RST;
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
   end
   else
   begin
      // R16: strap caught once, after the synchroniser has settled
      if (!strap_done_q)
      begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         if (strap_cnt_q == `FDP_STRAP_WAIT)
         begin
            strap_done_q <= 1'b1;
            cfg_q[`FDP_CFG_DUAL] <= strap_s;
         end
      end
      if (wr_en && addr == `FDP_OFS_DRV_OUT)
         drv_out_q <= pwdata[7:0];
      if (wr_en && addr == `FDP_OFS_CFG)
         cfg_q <= pwdata[7:0];
      // R10: either rate register updates the live rate
      if (wr_en && addr == `FDP_OFS_DSR)
      begin
         dsr_q <= pwdata[1:0];
         rate_q <= pwdata[1:0];
      end
      if (wr_en && addr == `FDP_OFS_CCR)
      begin
         ccr_q <= pwdata[1:0];
         rate_q <= pwdata[1:0];
      end
      if (wr_en && addr == `FDP_OFS_MODE)
         mode_q <= pwdata[7:0];
      if (wr_en && addr == `FDP_OFS_DMAMAP)
         map_q <= pwdata[2*NCH-1:0];
   end
end

////////////////////////////////////////////////////////////////////////
// APB answer: one wait state, pready and read data from flops

reg [31:0] rd_d;

// read mux; unmapped offsets read zero
always @*
begin
   rd_d = 32'h0000_0000;
   case (addr)
      `FDP_OFS_DRV_OUT: rd_d[7:0] = drv_out_q;
      `FDP_OFS_CFG: rd_d[7:0] = cfg_q;
      `FDP_OFS_DSR: rd_d[1:0] = dsr_q;
      `FDP_OFS_CCR: rd_d[1:0] = ccr_q;
      // R11: live disk change level
      `FDP_OFS_DIN: rd_d[`FDP_DIN_CHG] = chg_s;
      `FDP_OFS_MODE: rd_d[7:0] = mode_q;
      `FDP_OFS_DMAMAP: rd_d[2*NCH-1:0] = map_q;
      default: rd_d = 32'h0000_0000;
   endcase
end

// pready rises one cycle into the access phase and drops after
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
   end
   else if (psel && penable && !pready)
   begin
      pready <= 1'b1;
      pslverr <= ~hit(addr);
      prdata <= pwrite ? 32'h0000_0000 : rd_d;
   end
   else
   begin
      pready <= 1'b0;
      pslverr <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////
// drive interface outputs

reg dens_hi;
reg sel0_act;
reg sel1_act;
reg [1:0] dsel_n;

// select decode, encode and motor merge
always @*
begin
   // R1: 500K and 1M count as high density
   dens_hi = (rate_q == `FDP_RATE_500K) || (rate_q == `FDP_RATE_1M);
   sel0_act = drv_out_q[`FDP_DRVO_EN] && drv_out_q[1:0] == 2'h0;
   sel1_act = drv_out_q[`FDP_DRVO_EN] && drv_out_q[1:0] == 2'h1;
   // R7: merge motor 0 only when its pin carries the rate
   if (cfg_q[`FDP_CFG_MOTOR0_RATE] && cfg_q[`FDP_CFG_MERGE0])
      sel0_act = sel0_act | drv_out_q[`FDP_DRVO_MOTOR0];
   // R8: merge motor 1 only when its pin is the aux port
   if (cfg_q[`FDP_CFG_MOTOR1_AUX] && cfg_q[`FDP_CFG_MERGE1])
      sel1_act = sel1_act | drv_out_q[`FDP_DRVO_MOTOR1];
   // R5: decoded, active low
   dsel_n = {~sel1_act, ~sel0_act};
   // R6: encoded select for four drives
   if (cfg_q[`FDP_CFG_ENC])
      dsel_n = drv_out_q[`FDP_DRVO_EN] ? ~drv_out_q[1:0] : 2'b11;
end

// drive pins registered so every output starts from a flop
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      density_select <= 1'b0;
      step_dir <= 1'b0;
      // R18: selects idle until software enables them
      drive_select_n <= 2'b11;
      motor_on_0 <= 1'b0;
      motor_on_1 <= 1'b0;
      rate_select_out <= 1'b0;
      read_gate_diag <= 1'b0;
      full_infrared_mode <= 1'b1;
   end
   else
   begin
      full_infrared_mode <= ~cfg_q[`FDP_CFG_DUAL];
      // R9: shared pin carries drive-1 select in dual serial mode
      if (cfg_q[`FDP_CFG_DUAL])
         density_select <= dsel_n[1];
      else
         // R2: polarity by config bit 5
         density_select <= dens_hi ^ cfg_q[`FDP_CFG_DENS_POL];
      drive_select_n[0] <= dsel_n[0];
      // drive 1 select has no pin of its own outside dual serial
      drive_select_n[1] <= cfg_q[`FDP_CFG_DUAL] ? dsel_n[1] : 1'b1;
      // R3: active steps inward
      // R4: held inactive during read or write
      step_dir <= fdc_seek_in & ~fdc_rw_busy;
      // R10: rate pin shows the last written rate
      rate_select_out <= rate_q[0];
      motor_on_0 <= cfg_q[`FDP_CFG_MOTOR0_RATE] ? rate_q[0]
         : drv_out_q[`FDP_DRVO_MOTOR0];
      motor_on_1 <= cfg_q[`FDP_CFG_MOTOR1_AUX] ? cfg_q[`FDP_CFG_AUX_VAL]
         : drv_out_q[`FDP_DRVO_MOTOR1];
      // R12: disk change reused as read gate diagnostic
      read_gate_diag <= mode_q[`FDP_MODE_READ_GATE] & chg_s;
   end
end

////////////////////////////////////////////////////////////////////////
// DMA request and acknowledge routing

reg [NCH-1:0] ack_fdc;
reg [NCH-1:0] ack_ser;
reg [NCH-1:0] ack_par;
reg iowr_s2;
reg iord_s2;

genvar gi;
generate
   for (gi = 0; gi < NCH; gi = gi + 1)
   begin : g_ch
      // R15: per-channel owner selects the request source
      // R14: active-high request, R18: none owner after reset
      always @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            drq[gi] <= 1'b0;
         else
            case (owner(map_q, gi))
               `FDP_OWN_FDC: drq[gi] <= fdc_dma_req;
               `FDP_OWN_SER: drq[gi] <= ser_dma_req;
               `FDP_OWN_PAR: drq[gi] <= par_dma_req;
               default: drq[gi] <= 1'b0;
            endcase
      end
      // R13: a low acknowledge belongs to the channel owner
      always @*
      begin
         ack_fdc[gi] = ~dack_s[gi] && owner(map_q, gi) == `FDP_OWN_FDC;
         ack_ser[gi] = ~dack_s[gi] && owner(map_q, gi) == `FDP_OWN_SER;
         ack_par[gi] = ~dack_s[gi] && owner(map_q, gi) == `FDP_OWN_PAR;
      end
   end
endgenerate

// R13: strobes count as DMA transfers only under acknowledge
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      fdc_dack <= 1'b0;
      ser_dack <= 1'b0;
      par_dack <= 1'b0;
      iowr_s2 <= 1'b1;
      iord_s2 <= 1'b1;
      fdc_dma_wr <= 1'b0;
      fdc_dma_rd <= 1'b0;
   end
   else
   begin
      fdc_dack <= |ack_fdc;
      ser_dack <= |ack_ser;
      par_dack <= |ack_par;
      iowr_s2 <= iowr_s;
      iord_s2 <= iord_s;
      // falling strobe edge gives one pulse per transfer
      fdc_dma_wr <= (|ack_fdc) & iowr_s2 & ~iowr_s;
      fdc_dma_rd <= (|ack_fdc) & iord_s2 & ~iord_s;
   end
end

endmodule

//--- src/fdp_consts.vh
// constants of the floppy drive pin control block: offsets, field
// positions, reset values and clock figures.
// assumes an APB slave with 32-bit data, one aligned word per register.
//
// Operation
// R1: density select shows high rate (500K/1M) versus low rate (250K/300K).
// R2: config bit 5 inverts or keeps density select polarity.
// R3: during a seek, step direction active means inward, inactive outward.
// R4: step direction held inactive while a read or write runs.
// R5: two active-low decoded drive selects follow output register bits 0, 1.
// R6: config bit 7 set encodes the two selects to address four drives.
// R7: motor-0 pin as rate select may merge motor-0 into drive-0 select.
// R8: motor-1 pin as aux port may merge motor-1 into drive-1 select.
// R9: drive-1 select shares the density pin, only in dual serial mode.
// R10: rate select output follows whichever rate register was written last.
// R11: disk change input level is readable in the input register.
// R12: mode command may reuse disk change as read gate diagnostic input.
// R13: active-low DMA acknowledge enables write and read strobes as DMA.
// R14: active-high DMA request tells the DMA controller a transfer is due.
// R15: each DMA channel is assignable to floppy, serial or parallel port.
// R16: strap sampled at power-up picks full infrared or dual serial default.
// R17: logic runs from one input clock.
// R18: after reset drive selects and DMA requests stay deasserted.
`ifndef FDP_CONSTS_VH
`define FDP_CONSTS_VH

// clock figures
`define FDP_DOC_CLK_HZ 48000000
`define FDP_PCLK_HZ 20000000

// register byte offsets
`define FDP_ADDR_W 5
`define FDP_OFS_DRV_OUT 5'h00
`define FDP_OFS_CFG 5'h04
`define FDP_OFS_DSR 5'h08
`define FDP_OFS_CCR 5'h0C
`define FDP_OFS_DIN 5'h10
`define FDP_OFS_MODE 5'h14
`define FDP_OFS_DMAMAP 5'h18

// output register fields
`define FDP_DRVO_SEL_LO 0
`define FDP_DRVO_EN 2
`define FDP_DRVO_MOTOR0 4
`define FDP_DRVO_MOTOR1 5

// configuration register fields
`define FDP_CFG_MERGE0 0
`define FDP_CFG_MERGE1 1
`define FDP_CFG_MOTOR0_RATE 2
`define FDP_CFG_MOTOR1_AUX 3
`define FDP_CFG_AUX_VAL 4
`define FDP_CFG_DENS_POL 5
`define FDP_CFG_DUAL 6
`define FDP_CFG_ENC 7

// input register and mode register fields
`define FDP_DIN_CHG 7
`define FDP_MODE_READ_GATE 0

// rate codes: 0=500K 1=300K 2=250K 3=1M
`define FDP_RATE_500K 2'h0
`define FDP_RATE_1M 2'h3

// DMA owner codes
`define FDP_OWN_FDC 2'h0
`define FDP_OWN_SER 2'h1
`define FDP_OWN_PAR 2'h2
`define FDP_OWN_NONE 2'h3

// reset values
`define FDP_DRVO_RST 8'h00
`define FDP_CFG_RST 8'h00
`define FDP_MODE_RST 8'h00
`define FDP_RATE_RST 2'h2
`define FDP_DMAMAP_RST 6'h3F

// strap counter value at capture; strap caught on the fourth edge after reset release (after the synchroniser)
`define FDP_STRAP_WAIT 2'h3

`endif

//--- src/fdp_sync.v
// two-flop synchroniser for a vector of pin inputs.
// assumes inputs are asynchronous to pclk; RST_VAL is the idle pin level.
`timescale 1ns/100ps
module fdp_sync
#(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
)
(
   input wire pclk,
   input wire presetn,
   input wire [WIDTH-1:0] d,
   output reg [WIDTH-1:0] q
);

reg [WIDTH-1:0] meta_q;

// first stage feeds only the second stage
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
   end
   else
   begin
      meta_q <= d;
      q <= meta_q;
   end
end

endmodule

//--- verification/fdp_dma_host.sv
// host DMA controller model facing the request pins.
// assumes one request at a time; answers promptly or slowly.
`timescale 1ns/100ps
module fdp_dma_host
(
   input wire pclk,
   input wire [2:0] drq,
   input wire slow,
   input wire rd_sel,
   output reg [2:0] dack_n,
   output reg iowr_n,
   output reg iord_n
);
   integer c;
   initial
   begin
      dack_n = 3'h7;
      iowr_n = 1'b1;
      iord_n = 1'b1;
   end
   always
   begin
      @(posedge pclk);
      if (|drq)
      begin
         c = drq[2] ? 2 : (drq[1] ? 1 : 0);
         repeat (slow ? 6 : 1) @(posedge pclk);
         dack_n[c] <= 1'b0;
         repeat (4) @(posedge pclk);
         iord_n <= ~rd_sel;
         iowr_n <= rd_sel;
         // three cycles low so the synchroniser sees it
         repeat (3) @(posedge pclk);
         iowr_n <= 1'b1;
         iord_n <= 1'b1;
         repeat (2) @(posedge pclk);
         dack_n <= 3'h7;
         while (drq[c]) @(posedge pclk);
      end
   end
endmodule

//--- verification/fdp_pin_ctrl_props.sv
// assertions on the pin control ports.
// assumes the single pclk domain; bound into every instance.
`timescale 1ns/100ps
module fdp_pin_ctrl_props
#(
   parameter NCH = 3
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire pready,
   input wire pslverr,
   input wire fdc_seek_in,
   input wire fdc_rw_busy,
   input wire fdc_dma_req,
   input wire ser_dma_req,
   input wire par_dma_req,
   input wire disk_change_in,
   input wire step_dir,
   input wire [1:0] drive_select_n,
   input wire rate_select_out,
   input wire read_gate_diag,
   input wire [NCH-1:0] drq,
   input wire fdc_dack,
   input wire fdc_dma_wr,
   input wire full_infrared_mode
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_step_in: assert property ((fdc_seek_in && !fdc_rw_busy) |=> step_dir)
      else $error("step_dir low during seek");
   a_step_rw: assert property (fdc_rw_busy |=> !step_dir)
      else $error("step_dir high while busy");
   a_pready_wait: assert property ((psel && penable && !pready) |=> pready)
      else $error("pready late");
   a_pready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_slverr_unmap: assert property ((psel && penable && pready
      && paddr[4:0] > 5'h18) |-> pslverr)
      else $error("unmapped access not refused");
   // rate pin moves only two edges after a rate register write
   a_rate_src: assert property ($changed(rate_select_out) |->
      $past(psel && penable && pready && pwrite
      && (paddr[4:0] == 5'h08 || paddr[4:0] == 5'h0C), 2))
      else $error("rate pin moved without rate write");
   a_gate_src: assert property (read_gate_diag |->
      $past(disk_change_in, 3))
      else $error("read gate without disk change");
   a_wr_dack: assert property (fdc_dma_wr |-> fdc_dack ##1 !fdc_dma_wr)
      else $error("dma write strobe outside acknowledge");
   a_sel_dual: assert property (full_infrared_mode [*3] |->
      drive_select_n[1])
      else $error("drive 1 select outside dual mode");
   a_drq_idle: assert property (!(fdc_dma_req || ser_dma_req
      || par_dma_req) [*2] |-> drq == 0)
      else $error("drq without request");
endmodule
bind fdp_pin_ctrl fdp_pin_ctrl_props #(.NCH(NCH)) u_props (.*);

//--- verification/fdp_pin_ctrl_tb.sv
// self-checking bench of the floppy drive pin control block.
// assumes the DMA host model drives acknowledge and strobes.
`timescale 1ns/100ps
`include "fdp_consts.vh"
module fdp_pin_ctrl_tb;
   reg pclk, presetn, psel, penable, pwrite, e, slow, rd_sel;
   reg [31:0] paddr, pwdata, r;
   reg fdc_seek_in, fdc_rw_busy, fdc_dma_req, ser_dma_req, par_dma_req;
   reg mode_strap, disk_change_in;
   wire [31:0] prdata;
   wire pready, pslverr, density_select, step_dir, motor_on_0, motor_on_1;
   wire rate_select_out, read_gate_diag, fdc_dack, ser_dack, par_dack;
   wire fdc_dma_wr, fdc_dma_rd, full_infrared_mode, iowr_n, iord_n;
   wire [1:0] drive_select_n;
   wire [2:0] drq, dack_n;
   integer miscompares, checks_done, nwr, nrd, k, n, t, ch, ow;
   reg [7:0] v;
   fdp_pin_ctrl #(.NCH(3)) u_dut (.*);
   fdp_dma_host u_host (.*);
   always #25 pclk = ~pclk;
   // count strobe pulses handed to the floppy side
   always @(posedge pclk)
   begin
      if (fdc_dma_wr === 1'b1) nwr <= nwr + 1;
      if (fdc_dma_rd === 1'b1) nrd <= nrd + 1;
   end
   ////////////////////////////////////////////////////////////////////////
   task chk(input [47:0] nm, input [31:0] s, input [31:0] x);
   begin
      checks_done = checks_done + 1;
      if (s !== x)
      begin
         miscompares = miscompares + 1;
         $display("ERROR %0s exp %h got %h", nm, x, s);
      end
   end
   endtask
   task tick(input integer c);
      repeat (c) @(posedge pclk);
   endtask
   // decoded select pair, motor merged in where enabled, active low
   function [1:0] exp_dsel(input [3:0] c, input [7:0] d);
      reg s0, s1;
      begin
         s0 = (d[2] && d[1:0] == 2'h0) || (c[2] && c[0] && d[4]);
         s1 = (d[2] && d[1:0] == 2'h1) || (c[3] && c[1] && d[5]);
         exp_dsel = {~s1, ~s0};
      end
   endfunction
   // one idle edge first, so psel is never assigned twice in a step
   task apb(input w, input [4:0] a, input [31:0] d);
   begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {27'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n = n + 1;
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   task rst(input s);
   begin
      presetn <= 1'b0;
      mode_strap <= s;
      tick(12);
      presetn <= 1'b1;
      tick(8);
   end
   endtask
   task test_done;
   begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watchdog: the whole run needs well under a thousand cycles
   initial
   begin
      repeat (20000) @(posedge pclk);
      miscompares = miscompares + 1;
      test_done;
   end
   initial
   begin
      {pclk, presetn, psel, penable, pwrite, slow, rd_sel} = 7'h0;
      {paddr, pwdata} = 64'h0;
      {fdc_seek_in, fdc_rw_busy, fdc_dma_req, ser_dma_req} = 4'h0;
      {par_dma_req, mode_strap, disk_change_in} = 3'h0;
      {miscompares, checks_done, nwr, nrd} = 128'h0;
      t = $urandom(89015);
      rst(1'b0);
      chk("dsel", drive_select_n, 2'h3);
      chk("drq", drq, 3'h0);
      chk("fir", full_infrared_mode, 1'b1);
      apb(1'b0, 5'h1C, 0);
      chk("slverr", e, 1'b1);
      chk("rdata", r, 0);
      for (k = 0; k < 16; k = k + 1)
      begin
         v = $urandom;
         fdc_seek_in <= v[0];
         fdc_rw_busy <= v[1];
         tick(2);
         chk("step", step_dir, v[0] & ~v[1]);
      end
      // alternate the two rate registers, last write wins
      for (k = 0; k < 12; k = k + 1)
      begin
         v = $urandom & 8'h3C;
         t = $urandom % 4;
         apb(1'b1, `FDP_OFS_CFG, v);
         apb(1'b1, k[0] ? `FDP_OFS_CCR : `FDP_OFS_DSR, t);
         tick(2);
         chk("rate", rate_select_out, t[0]);
         chk("dens", density_select, (t == 0 || t == 3) ^ v[5]);
         chk("motor_on_0", motor_on_0, v[2] & t[0]);
         chk("motor_on_1", motor_on_1, v[3] & v[4]);
      end
      // decoded selects in dual serial mode, random motor merging
      for (k = 0; k < 16; k = k + 1)
      begin
         v = $urandom;
         apb(1'b1, `FDP_OFS_CFG, {4'h4, v[3:0]});
         t = $urandom & 32'h37;
         apb(1'b1, `FDP_OFS_DRV_OUT, t);
         tick(2);
         chk("dsel", drive_select_n, exp_dsel(v[3:0], t[7:0]));
      end
      apb(1'b1, `FDP_OFS_CFG, 8'hC0);
      for (k = 0; k < 8; k = k + 1)
      begin
         apb(1'b1, `FDP_OFS_DRV_OUT, k);
         tick(2);
         chk("dsel", drive_select_n, k[2] ? {~k[1:0]} : 2'h3);
         chk("dens1", density_select, k[2] ? {~k[1]} : 1'b1);
      end
      apb(1'b1, `FDP_OFS_CFG, 8'h80);
      tick(3);
      chk("dsel1", drive_select_n[1], 1'b1);
      apb(1'b1, `FDP_OFS_MODE, 1);
      for (k = 0; k < 4; k = k + 1)
      begin
         disk_change_in <= k[0];
         tick(4);
         apb(1'b0, `FDP_OFS_DIN, 0);
         chk("din", r[7], k[0]);
         chk("read_gate_diag", read_gate_diag, k[0]);
      end
      // every channel to every owner, prompt and slow host
      for (k = 0; k < 9; k = k + 1)
      begin
         ch = k / 3;
         ow = k % 3;
         slow <= $urandom;
         rd_sel <= $urandom;
         nwr = 0;
         nrd = 0;
         apb(1'b1, `FDP_OFS_DMAMAP,
            32'h3F & ~(32'h3 << (2 * ch)) | (ow << (2 * ch)));
         {par_dma_req, ser_dma_req, fdc_dma_req} <= 3'h1 << ow;
         tick(2);
         chk("drq", drq, 3'h1 << ch);
         for (t = 0; t < 20 && dack_n[ch] !== 1'b0; t = t + 1)
            tick(1);
         tick(4);
         chk("dack", {par_dack, ser_dack, fdc_dack}, 3'h1 << ow);
         for (t = 0; t < 40 && dack_n !== 3'h7; t = t + 1)
            tick(1);
         {par_dma_req, ser_dma_req, fdc_dma_req} <= 3'h0;
         tick(6);
         chk("nwr", nwr, ow == 0 && !rd_sel);
         chk("nrd", nrd, ow == 0 && rd_sel);
      end
      rst(1'b1);
      chk("fir", full_infrared_mode, 1'b0);
      test_done;
   end
endmodule
